// [rxop_params.svh]
`ifndef RXOP_PARAMS_SVH
`define RXOP_PARAMS_SVH
// Data bus width, 16-bit word mode
`define RXOP_DATA_W 16
// Cell length in words (53-byte cell, 16-bit bus, padded)
`define RXOP_CELL_WORDS 6'h1B
// Chunk length in words
`define RXOP_CHUNK_WORDS 6'h20
// Reset values
`define RXOP_DATA_RST 16'h0000
`endif

// [rxop_pkg.sv]
package rxop_pkg;
	typedef enum logic [1:0] {
		RXOP_MODE_CELL = 2'b00,
		RXOP_MODE_PKT = 2'b01,
		RXOP_MODE_CHUNK = 2'b10,
		RXOP_MODE_CLEAR = 2'b11
	} rxop_mode_t;
	typedef struct packed {
		logic [15:0] data;
		logic sop;
		logic eop;
		logic err;
	} rxop_word_t;
	typedef struct packed {
		logic [15:0] data;
		logic start;
		logic eop;
		logic valid;
		logic parity;
		logic err;
		logic drive;
	} rxop_out_t;
endpackage : rxop_pkg

// [rxop_port.sv]
`timescale 1ns/1ps
`include "rxop_params.svh"
// How it works
// - Enable high keeps data bus tristated
// - Cell mode: enable low pops, drives next edge
// - Packet mode: enable low pops, drives next edge
// - Start-of-cell high with first cell word
// - Start-of-packet high with first packet word
// - Chunk start pulses with first chunk word
// - End-of-packet high with last packet word
// - Valid high only while outputs are valid
// - Odd parity output with each word
module rxop_port (
	input wire logic sys_clk_i,
	input wire logic nrst_i,
	input wire rxop_pkg::rxop_mode_t mode_i,
	input wire logic link_clk_i,
	input wire logic rx_output_enable_n_i,
	input wire rxop_pkg::rxop_word_t queue_word_i,
	input wire logic queue_valid_i,
	output logic queue_pop_o,
	output logic [15:0] rx_data_o,
	output logic rx_data_oe_o,
	output logic rx_start_o,
	output logic pkt_rx_end_of_packet_o,
	output logic pkt_rx_valid_o,
	output logic rx_parity_o,
	output logic pkt_rx_error_o
);
	////////////////////////////////////////////////////////////////////////
	logic rst_meta_q;
	logic rst_n_q;
	always_ff @(posedge sys_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			rst_meta_q <= 1'b0;
			rst_n_q <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_n_q <= rst_meta_q;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// Link clock and enable both come from the far domain
	logic link_clk_s;
	logic oe_n_s;
	logic link_clk_prev_q;
	rxop_sync u_sync_clk (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_q),
		.d_i(link_clk_i),
		.q_o(link_clk_s)
	);
	rxop_sync u_sync_oe (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_q),
		.d_i(rx_output_enable_n_i),
		.q_o(oe_n_s)
	);
	always_ff @(posedge sys_clk_i or negedge rst_n_q)
	begin
		if (!rst_n_q)
			link_clk_prev_q <= 1'b0;
		else
			link_clk_prev_q <= link_clk_s;
	end
	////////////////////////////////////////////////////////////////////////
	function automatic logic odd_par(input logic [15:0] w);
		odd_par = ~(^w);
	endfunction : odd_par
	wire link_rise = link_clk_s & ~link_clk_prev_q;
	// Enable is sampled on the link edge, as the processor sees it
	wire oe_on = ~oe_n_s;
	wire pop = link_rise & oe_on & queue_valid_i;
	wire is_cell = (mode_i == rxop_pkg::RXOP_MODE_CELL);
	wire is_chunk = (mode_i == rxop_pkg::RXOP_MODE_CHUNK);
	wire is_pkt_any = ~is_cell;
	// Word position counter finds cell and chunk boundaries
	logic [5:0] pos_q;
	wire [5:0] limit = is_cell ? `RXOP_CELL_WORDS : `RXOP_CHUNK_WORDS;
	wire at_first = (pos_q == 6'h00);
	// Tracked in every mode so a chunk count starts clean after a packet end
	wire wrap = (pos_q == limit - 6'h01) | (is_pkt_any & queue_word_i.eop);
	wire [5:0] pos_d = wrap ? 6'h00 : pos_q + 6'h01;
	wire start_d = is_cell ? at_first
		: is_chunk ? at_first
		: queue_word_i.sop;
	////////////////////////////////////////////////////////////////////////
	rxop_pkg::rxop_out_t out_q;
	rxop_pkg::rxop_out_t out_d;
	wire word_par = odd_par(queue_word_i.data);
	// Held words stay on the bus; flags only mark a fresh word
	assign out_d = '{
		data: pop ? queue_word_i.data : out_q.data,
		start: pop & start_d,
		eop: pop & is_pkt_any & queue_word_i.eop,
		valid: pop & is_pkt_any,
		parity: pop ? word_par : out_q.parity,
		err: pop & is_pkt_any & queue_word_i.err,
		drive: oe_on
	};
	always_ff @(posedge sys_clk_i or negedge rst_n_q)
	begin
		if (!rst_n_q)
			pos_q <= 6'h00;
		else if (pop)
			pos_q <= pos_d;
	end
	always_ff @(posedge sys_clk_i or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			out_q <= '0;
		end
		else if (link_rise)
		begin
			out_q <= out_d;
		end
	end
	////////////////////////////////////////////////////////////////////////
	logic pop_q;
	always_ff @(posedge sys_clk_i or negedge rst_n_q)
	begin
		if (!rst_n_q)
			pop_q <= 1'b0;
		else
			pop_q <= pop;
	end
	assign queue_pop_o = pop_q;
	assign rx_data_o = out_q.data;
	assign rx_data_oe_o = out_q.drive;
	assign rx_start_o = out_q.start;
	assign pkt_rx_end_of_packet_o = out_q.eop;
	assign pkt_rx_valid_o = out_q.valid;
	assign rx_parity_o = out_q.parity;
	assign pkt_rx_error_o = out_q.err;
endmodule : rxop_port

// [rxop_port_monitor.sv]
`timescale 1ns/1ps
module rxop_port_monitor (
	input logic sys_clk_i,
	input logic nrst_i,
	input rxop_pkg::rxop_mode_t mode_i,
	input logic pkt_rx_end_of_packet_o,
	input logic rx_output_enable_n_i,
	input rxop_pkg::rxop_word_t queue_word_i,
	input logic queue_pop_o,
	input logic [15:0] rx_data_o,
	input logic rx_data_oe_o,
	input logic rx_start_o,
	input logic pkt_rx_valid_o,
	input logic rx_parity_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!nrst_i);
	// Sixteen cycles covers sync delay plus one whole link period
	property p_off; rx_output_enable_n_i[*8] ##1
		rx_output_enable_n_i[*8] |-> !rx_data_oe_o; endproperty
	a_off: assert property (p_off) else $error("bus on");
	property p_dat; queue_pop_o |-> rx_data_o == queue_word_i.data; endproperty
	a_dat: assert property (p_dat) else $error("data");
	property p_drv; queue_pop_o |-> rx_data_oe_o; endproperty
	a_drv: assert property (p_drv) else $error("pop");
	property p_gap; queue_pop_o |=> !queue_pop_o[*6]; endproperty
	a_gap: assert property (p_gap) else $error("gap");
	property p_stb; queue_pop_o |=> $stable(rx_data_o); endproperty
	a_stb: assert property (p_stb) else $error("hold");
	property p_st; rx_start_o |-> rx_data_oe_o; endproperty
	a_st: assert property (p_st) else $error("start");
	property p_par; rx_data_oe_o |-> rx_parity_o ^ (^rx_data_o); endproperty
	a_par: assert property (p_par) else $error("parity");
	property p_val; pkt_rx_valid_o |-> rx_data_oe_o; endproperty
	a_val: assert property (p_val) else $error("valid");
	property p_eop; queue_pop_o |-> pkt_rx_end_of_packet_o ==
		(mode_i != rxop_pkg::RXOP_MODE_CELL && queue_word_i.eop); endproperty
	a_eop: assert property (p_eop) else $error("end");
	property p_vok; queue_pop_o |-> pkt_rx_valid_o ==
		(mode_i != rxop_pkg::RXOP_MODE_CELL); endproperty
	a_vok: assert property (p_vok) else $error("valid mode");
endmodule : rxop_port_monitor
bind rxop_port rxop_port_monitor u_mon (.*);

// [rxop_proc.sv]
`timescale 1ns/1ps
module rxop_proc (
	input logic oe_i,
	input logic st_i,
	output logic clk_o = 1'b0,
	output int s_o = 0
);
	always #100 clk_o = ~clk_o;
	// Counts starts only while the bus is driven
	always @(posedge clk_o) s_o <= s_o + int'(oe_i & st_i);
endmodule : rxop_proc

// [rxop_sync.sv]
`timescale 1ns/1ps
module rxop_sync (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic d_i,
	output logic q_o
);
	logic meta_q;
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			meta_q <= 1'b0;
			q_o <= 1'b0;
		end
		else
		begin
			meta_q <= d_i;
			q_o <= meta_q;
		end
	end
endmodule : rxop_sync

// [tb_rxop_port.sv]
`timescale 1ns/1ps
module tb_rxop_port;
	logic c = 1'b0, r = 1'b0, g = 1'b0, lc, p, oe, st;
	logic [15:0] h = 16'h0000;
	rxop_pkg::rxop_mode_t m = rxop_pkg::RXOP_MODE_CELL;
	int bad_count = 0, checked = 0, cyc = 0, s, s0;
	always #12.5 c = ~c;
	always @(posedge c) h <= #1 h + 16'(p);
	always @(posedge c) if (++cyc > 4000) summarize();
	rxop_port u_rxop_port (.sys_clk_i(c), .nrst_i(r), .mode_i(m),
		.link_clk_i(lc), .rx_output_enable_n_i(!g), .queue_valid_i(1'b1),
		.queue_word_i({h, h[5:0] == 6'h00, m != 2'h0 && &h[5:0], 1'b0}),
		.queue_pop_o(p), .rx_data_o(), .rx_data_oe_o(oe), .rx_start_o(st),
		.pkt_rx_end_of_packet_o(), .pkt_rx_valid_o(), .rx_parity_o(),
		.pkt_rx_error_o());
	rxop_proc u_rxop_proc (.oe_i(oe), .st_i(st), .clk_o(lc), .s_o(s));
	task run(input logic [1:0] k, input int e);
		#1 m = rxop_pkg::rxop_mode_t'(k);
		s0 = s;
		g = 1'b1;
		wait (h[5:0] == 6'h3F);
		wait (h[5:0] == 6'h00);
		@(posedge c);
		#1 g = 1'b0;
		repeat (24) @(posedge c);
		checked++;
		s0 = s - s0;
		if ({h[5:0], s0} !== {6'h00, e})
		begin
			bad_count++;
			$display("[FAIL] %0t %h %h", $time, s0, e);
		end
	endtask : run
	task summarize;
		bad_count += int'(cyc > 4000);
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : summarize
	initial
	begin
		repeat (6) @(posedge c);
		#1 r = 1'b1;
		repeat (4) @(posedge c);
		run(2'h0, 3);
		run(2'h1, 1);
		run(2'h2, 2);
		run(2'h3, 1);
		summarize();
	end
endmodule : tb_rxop_port
